/* rtl/sop_pkg.sv */
package sop_pkg;
  // system clock rate and derived counts
  localparam int unsigned CLK_SYS_MHZ       = 200;
  localparam int unsigned STORE_MIN_MS      = 10;
  localparam int unsigned STORE_MIN_CYCLES  = STORE_MIN_MS * 1000 * CLK_SYS_MHZ;
  // frame lengths
  localparam int unsigned FEATURE_BITS      = 18;
  localparam int unsigned CAL_BITS          = 17;
  localparam int unsigned SHIFT_W           = 18;
  // mode-entry pulses needed after data pin raised
  localparam logic [1:0]  ENTRY_PULSES      = 2'h2;
  // calibration field positions, lsb first in field order
  localparam int unsigned STBY_LSB          = 0;
  localparam int unsigned STBY_W            = 5;
  localparam int unsigned HYST_LSB          = 5;
  localparam int unsigned HYST_W            = 3;
  localparam int unsigned HUSH_LSB          = 8;
  localparam int unsigned HUSH_W            = 4;
  localparam int unsigned CHAM_LSB          = 12;
  localparam int unsigned CHAM_W            = 5;
  // reset values
  localparam logic [SHIFT_W-1:0]  SHIFT_RST = 18'h00000;
  localparam logic [CAL_BITS-1:0] CAL_RST   = 17'h00000;
  localparam logic [4:0]          CNT_RST   = 5'h00;

  typedef enum logic [2:0] {
    SOP_BASE,
    SOP_FIRST_TEST,
    SOP_ARMED,
    SOP_PROGRAM,
    SOP_DONE
  } sop_mode_t;

  // raw pins, grouped
  typedef struct packed {
    logic mode_entry;
    logic data;
    logic shift_clk;
    logic store;
  } sop_pins_t;

  // calibration trim settings
  typedef struct packed {
    logic [CHAM_W-1:0] chamber_test_voltage_trim;
    logic [HUSH_W-1:0] hush_sensitivity_trim;
    logic [HYST_W-1:0] hysteresis_trim;
    logic [STBY_W-1:0] standby_sensitivity_trim;
  } sop_cal_t;
endpackage

/* rtl/sop_loader.sv */
`timescale 1ns/1ps
// Overview of operation
// [RULE1] serial bits sampled on shift clock rising edge, kept in nonvolatile store on commit
// [RULE2] fixture powers up with all test pins low, detect high: base mode
// [RULE3] mode pin high, data high, then two low-high mode pulses enter programming
// [RULE4] eighteen feature bits shifted, one captured per shift clock edge
// [RULE5] store pulse high then low copies shift register into nonvolatile memory
// [RULE6] changing options needs power cycle and full resend; no partial update
// [RULE7] calibration load is seventeen bits: standby, hysteresis, hush, chamber, lsb first
// [RULE8] shift and store edges ignored outside programming test modes
module sop_loader
  import sop_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = STORE_MIN_CYCLES
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // fixture pins
  input  wire sop_pins_t           pins,
  input  wire logic                detect,
  input  wire logic                cal_select,
  // stored results
  output sop_mode_t                mode,
  output logic [FEATURE_BITS-1:0]  feature_options,
  output sop_cal_t                 cal_trim,
  output logic                     store_done,
  output logic                     short_store
);

  sop_pins_t              meta_q;
  sop_pins_t              sync_q;
  sop_pins_t              prev_q;
  logic                   det_meta_q;
  logic                   det_q;
  sop_mode_t              mode_q;
  logic [1:0]             pulse_q;
  logic [SHIFT_W-1:0]     shift_q;
  logic [4:0]             cnt_q;
  logic [31:0]            width_q;
  logic [FEATURE_BITS-1:0] feat_q;
  logic [CAL_BITS-1:0]    cal_q;
  logic                   done_q;
  logic                   short_q;
  logic                   clk_rise;
  logic                   st_rise;
  logic                   st_fall;
  logic                   me_rise;
  logic                   in_prog;

  // two-flop synchronisers; first stage feeds nothing else
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_q     <= '0;
      sync_q     <= '0;
      prev_q     <= '0;
      det_meta_q <= 1'b0;
      det_q      <= 1'b0;
    end
    else
    begin
      meta_q     <= pins;
      sync_q     <= meta_q;
      prev_q     <= sync_q;
      det_meta_q <= detect;
      det_q      <= det_meta_q;
    end
  end

  // edge detection on synchronised pins
  assign clk_rise = sync_q.shift_clk & ~prev_q.shift_clk;
  assign st_rise  = sync_q.store & ~prev_q.store;
  assign st_fall  = ~sync_q.store & prev_q.store;
  assign me_rise  = sync_q.mode_entry & ~prev_q.mode_entry;
  assign in_prog  = (mode_q == SOP_PROGRAM); // see [RULE8]

  // mode sequencer; reset, or the mode pin dropping in first test mode, returns to base mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_q  <= SOP_BASE; // see [RULE2]
      pulse_q <= 2'h0;
    end
    else
    begin
      unique case (mode_q)
        SOP_BASE:
        begin
          // entry only with data and store low and detect high; the shift clock is not checked
          if (me_rise && det_q && !sync_q.data && !sync_q.store)
            mode_q <= SOP_FIRST_TEST; // see [RULE3]
        end
        SOP_FIRST_TEST:
        begin
          if (!sync_q.mode_entry)
            mode_q <= SOP_BASE;
          else if (sync_q.data)
          begin
            mode_q  <= SOP_ARMED; // see [RULE3]
            pulse_q <= 2'h0;
          end
        end
        SOP_ARMED:
        begin
          // count low-then-high returns of the mode pin with data held
          if (!sync_q.data)
            mode_q <= SOP_FIRST_TEST;
          else if (me_rise)
          begin
            if (pulse_q + 2'h1 == ENTRY_PULSES)
              mode_q <= SOP_PROGRAM; // see [RULE3]
            pulse_q <= pulse_q + 2'h1;
          end
        end
        SOP_PROGRAM:
        begin
          if (done_q)
            mode_q <= SOP_DONE;
        end
        SOP_DONE:
        begin
          // locked until power cycle so no partial rewrite is possible
          mode_q <= SOP_DONE; // see [RULE6]
        end
      endcase
    end
  end

  // serial capture; new bits enter at the top so first bit ends lsb
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      shift_q <= SHIFT_RST;
      cnt_q   <= CNT_RST;
    end
    else if (in_prog && clk_rise && !sync_q.store)
    begin
      shift_q <= {sync_q.data, shift_q[SHIFT_W-1:1]}; // see [RULE1] see [RULE4]
      if (cnt_q != 5'(SHIFT_W))
        cnt_q <= cnt_q + 5'h1;
    end
  end

  // store pulse width measured between synchronised edges
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      width_q <= 32'h00000000;
    else if (st_rise)
      width_q <= 32'h00000001;
    else if (sync_q.store && width_q != 32'hFFFFFFFF)
      width_q <= width_q + 32'h00000001;
  end

  // commit on falling edge of a long enough pulse; short pulses rejected
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      feat_q  <= '0;
      cal_q   <= CAL_RST;
      done_q  <= 1'b0;
      short_q <= 1'b0;
    end
    else if (in_prog && st_fall) // see [RULE8]
    begin
      if (width_q >= STORE_CYCLES)
      begin
        done_q <= 1'b1; // see [RULE5]
        if (cal_select)
          cal_q <= shift_q[SHIFT_W-1 -: CAL_BITS]; // see [RULE7]
        else
          feat_q <= shift_q; // see [RULE1] see [RULE4]
      end
      else
        short_q <= 1'b1;
    end
  end

  assign mode            = mode_q;
  assign feature_options = feat_q;
  assign cal_trim        = sop_cal_t'(cal_q);
  assign store_done      = done_q;
  assign short_store     = short_q;

  // assertions
  sequence s_store_fall;
    in_prog && st_fall && width_q >= STORE_CYCLES;
  endsequence

  property p_ignore_shift;
    @(posedge clk_sys) disable iff (reset)
      (!in_prog) |=> $stable(shift_q);
  endproperty
  a_ignore_shift: assert property (p_ignore_shift) else $error("shift outside program"); // see [RULE8]

  property p_ignore_store;
    @(posedge clk_sys) disable iff (reset)
      (!in_prog) |=> ($stable(feat_q) && $stable(cal_q));
  endproperty
  a_ignore_store: assert property (p_ignore_store) else $error("store outside program"); // see [RULE8]

  property p_shift_bit;
    @(posedge clk_sys) disable iff (reset)
      (in_prog && clk_rise && !sync_q.store) |=> shift_q[SHIFT_W-1] == $past(sync_q.data);
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("bit not captured"); // see [RULE4]

  property p_commit;
    @(posedge clk_sys) disable iff (reset)
      s_store_fall |=> done_q ##1 (mode_q == SOP_DONE);
  endproperty
  a_commit: assert property (p_commit) else $error("store not committed"); // see [RULE5]

  property p_feat_copy;
    @(posedge clk_sys) disable iff (reset)
      (s_store_fall and !cal_select) |=> feat_q == $past(shift_q);
  endproperty
  a_feat_copy: assert property (p_feat_copy) else $error("feature copy wrong"); // see [RULE1]

  property p_cal_copy;
    @(posedge clk_sys) disable iff (reset)
      (s_store_fall and cal_select) |=> cal_q == $past(shift_q[SHIFT_W-1:1]);
  endproperty
  a_cal_copy: assert property (p_cal_copy) else $error("calibration copy wrong"); // see [RULE7]

  property p_done_locked;
    @(posedge clk_sys) disable iff (reset)
      (mode_q == SOP_DONE) |=> (mode_q == SOP_DONE) && $stable(feat_q);
  endproperty
  a_done_locked: assert property (p_done_locked) else $error("stored options altered"); // see [RULE6]

  property p_entry;
    @(posedge clk_sys) disable iff (reset)
      (mode_q == SOP_ARMED && me_rise && sync_q.data && pulse_q == 2'h1) |=> in_prog;
  endproperty
  a_entry: assert property (p_entry) else $error("program mode not entered"); // see [RULE3]

  property p_base_reset;
    @(posedge clk_sys)
      reset |=> (mode_q == SOP_BASE);
  endproperty
  a_base_reset: assert property (p_base_reset) else $error("reset not in base mode"); // see [RULE2]

endmodule

/* tb/sop_fixture.sv */
`timescale 1ns/1ps
module sop_fixture
  import sop_pkg::*;
(
  // pacing clock
  input  wire logic clk_sys,
  // pins toward the device
  output sop_pins_t pins
);
  // all test pins low at power-up
  initial pins = '0;

  // idle: every pin back low; the device is not reset and keeps its last frame
  task automatic idle();
    @(negedge clk_sys);
    pins = '0;
  endtask

  // mode pin up and held, data up if any pulses are asked, then that many low-high mode pulses
  task automatic enter(input int pulses);
    @(negedge clk_sys);
    pins.mode_entry = 1'b1;
    repeat (4) @(negedge clk_sys);
    pins.data = (pulses > 0);
    repeat (pulses)
    begin
      repeat (4) @(negedge clk_sys);
      pins.mode_entry = 1'b0;
      repeat (4) @(negedge clk_sys);
      pins.mode_entry = 1'b1;
    end
    repeat (8) @(negedge clk_sys);
  endtask

  // lsb first; shift clock idles low between frames, 50 ns period
  task automatic shift(input logic [19:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      pins.data = v[i];
      #24 pins.shift_clk = 1'b1;
      #24 pins.shift_clk = 1'b0;
    end
  endtask

  // store pulse high then low; short widths only when a test asks
  task automatic store(input int cycles);
    @(negedge clk_sys);
    pins.store = 1'b1;
    repeat (cycles) @(negedge clk_sys);
    pins.store = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import sop_pkg::*;
;
  logic                    clk_sys;
  logic                    reset;
  sop_pins_t               pins;
  logic                    detect;
  logic                    cal_select;
  sop_mode_t               mode;
  logic [FEATURE_BITS-1:0] feature_options;
  sop_cal_t                cal_trim;
  logic                    store_done;
  logic                    short_store;
  int                      errors;
  int                      total_checks;
  sop_cal_t                cv;

  // short store width keeps the run small
  sop_loader #(.STORE_CYCLES(20)) DUT (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .pins            (pins),
    .detect          (detect),
    .cal_select      (cal_select),
    .mode            (mode),
    .feature_options (feature_options),
    .cal_trim        (cal_trim),
    .store_done      (store_done),
    .short_store     (short_store)
  );
  sop_fixture fx (
    .clk_sys (clk_sys),
    .pins    (pins)
  );

  // 200 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // reset stands in for a power cycle
  task automatic power(input logic cal);
    @(negedge clk_sys);
    reset = 1'b1;
    cal_select = cal;
    fx.idle();
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic t_ignore();
    power(0);
    fx.shift(20'hFFFFF, 18);
    fx.store(25);
    check(mode, SOP_BASE);
    check({31'h0, store_done}, 32'h0);
    check(feature_options, 18'h0);
  endtask

  task automatic t_entry();
    power(0);
    fx.enter(0);
    check(mode, SOP_FIRST_TEST);
    fx.idle();
    repeat (6) @(negedge clk_sys);
    check(mode, SOP_BASE);
    detect = 1'b0;
    fx.enter(2);
    check(mode, SOP_BASE);
    detect = 1'b1;
  endtask

  task automatic t_feature();
    power(0);
    fx.enter(2);
    check(mode, SOP_PROGRAM);
    fx.shift(20'h2D5B3, 18);
    fx.store(25);
    check(feature_options, 18'h2D5B3);
    check({31'h0, store_done}, 32'h1);
    check(mode, SOP_DONE);
    fx.shift(20'h15555, 18);
    fx.store(25);
    check(feature_options, 18'h2D5B3);
  endtask

  task automatic t_short();
    power(0);
    fx.enter(2);
    fx.shift(20'hABCDE, 20);
    fx.store(10);
    check({31'h0, short_store}, 32'h1);
    check({31'h0, store_done}, 32'h0);
    check(mode, SOP_PROGRAM);
    fx.store(25);
    check(feature_options, 18'h2AF37);
  endtask

  task automatic t_cal();
    cv.standby_sensitivity_trim = 5'h0A;
    cv.hysteresis_trim = 3'h5;
    cv.hush_sensitivity_trim = 4'h9;
    cv.chamber_test_voltage_trim = 5'h13;
    power(1);
    fx.enter(2);
    fx.shift({3'h0, cv}, 17);
    fx.store(25);
    check(cal_trim, cv);
    check(feature_options, 18'h0);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    detect = 1'b1;
    cal_select = 1'b0;
    errors = 0;
    total_checks = 0;
    t_ignore();
    t_entry();
    t_feature();
    t_short();
    t_cal();
    summarize();
  end

  // whole run is under two thousand cycles
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
endmodule
